// ==== design/isc_defines.svh ====
// register offsets, field positions, codes and reset values of the two-wire slave controller
`ifndef ISC_DEFINES_SVH
`define ISC_DEFINES_SVH
`define ISC_OFF_CTRL 8'h04
`define ISC_OFF_ENCLR 8'h14
`define ISC_OFF_ENSET 8'h16
`define ISC_OFF_FLAG 8'h18
`define ISC_OFF_STATUS 8'h1A
`define ISC_OFF_DATA 8'h28
`define ISC_ACK_CHOICE_BIT 18
`define ISC_CMD_HI 17
`define ISC_CMD_LO 16
`define ISC_MATCH_MODE_HI 15
`define ISC_MATCH_MODE_LO 14
`define ISC_AUTO_ACK_BIT 10
`define ISC_GROUP_BIT 9
`define ISC_RD_ACK_BIT 8
`define ISC_IRQ_ERROR_BIT 7
`define ISC_IRQ_BYTE_BIT 2
`define ISC_IRQ_HIT_BIT 1
`define ISC_IRQ_STOP_BIT 0
`define ISC_ST_CLKHOLD_BIT 7
`define ISC_ST_SR_BIT 4
`define ISC_ST_DIR_BIT 3
`define ISC_ST_RXNACK_BIT 2
`define ISC_CMD_NONE 2'h0
`define ISC_CMD_RSVD 2'h1
`define ISC_CMD_DONE 2'h2
`define ISC_CMD_NEXT 2'h3
`define ISC_MATCH_MASKED 2'h0
`define ISC_MATCH_DUAL 2'h1
`define ISC_MATCH_RANGE 2'h2
`define ISC_RESET_BYTE 8'h00
`define ISC_RESET_WORD 32'h0000_0000
`define ISC_RESET_FLAGS 4'h0
`define ISC_BITS_PER_BYTE 4'h8
`define ISC_FIRST_TX_BIT 4'h1
`endif

// ==== design/isc_pkg.sv ====
// types shared by the two-wire slave controller
package isc_pkg;
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_WAIT, ST_ACK, ST_RX, ST_RX_WAIT, ST_TX, ST_TX_ACK, ST_TX_WAIT
    } isc_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } isc_reg_req_t;

    typedef struct packed {
        logic [6:0] primary;
        logic [6:0] secondary;
    } isc_addr_cfg_t;

    typedef struct packed {
        logic ack_choice;
        logic [1:0] address_match_mode;
        logic auto_address_ack_enable;
        logic group_command_enable;
        logic smart_ack_on_read;
    } isc_ctrl_t;
endpackage

// ==== design/isc_slave_ctrl.sv ====
// two-wire slave: command strobes, address matching, acknowledge options and interrupt flags
// Overview of operation
// - command field is write strobe, reads zero
// - any valid command clears three transfer flags
// - done after write byte: ack, await start
// - done after read byte: just await start
// - next in master write: ack, receive byte
// - next after address read: ack, data-ready
// - next after read byte: send byte, get ack
// - mask mode: masked bits are don't care
// - dual mode: match either of two addresses
// - range mode: secondary up to primary inclusive
// - auto ack answers matching address itself
// - group mode: stop flag if addressed since stop
// - read-ack mode acks when data is read
// - mode settings act on the next cycle
// - reserved bits read as zero
// - enable-clear ones disable sources
// - enable-set ones enable sources
// - set and clear views share one enable
// - any error source sets error flag
// - writing one clears error flag
// - ack_choice zero acks, one nacks
// - address hit sets flag when auto ack is off; clearing it acks
// - completed byte sets byte-done flag
// - stop flag only for own transaction
`timescale 1ns/1ps
`include "isc_defines.svh"

module isc_slave_ctrl (
    input wire logic clk, // 125 MHz core clock
    input wire logic rst, // asynchronous reset, active high
    input wire logic ce, // clock enable, freezes all state while low
    input wire isc_pkg::isc_reg_req_t reg_req, // register access request
    output logic [31:0] reg_rdata, // read data, valid the cycle after rd
    input wire isc_pkg::isc_addr_cfg_t addr_cfg, // primary and secondary match values
    input wire logic [3:0] err_events, // error source pulses from timeout logic
    input wire logic scl_in, // bus clock level
    input wire logic sda_in, // bus data level
    output logic scl_out, // bus clock drive level, always low
    output logic scl_oe, // high while holding the bus clock low
    output logic sda_out, // bus data drive level, always low
    output logic sda_oe, // high while pulling the data line low
    output logic irq // interrupt request
);
    // address match against the selected mode, reserved mode never matches
    function automatic logic addr_hit(input logic [6:0] a, input isc_pkg::isc_addr_cfg_t c,
                                      input logic [1:0] mode);
        case (mode)
            `ISC_MATCH_MASKED: addr_hit = ((a ^ c.primary) & ~c.secondary) == 7'h00;
            `ISC_MATCH_DUAL: addr_hit = (a == c.primary) || (a == c.secondary);
            `ISC_MATCH_RANGE: addr_hit = (a <= c.primary) && (a >= c.secondary);
            default: addr_hit = 1'h0;
        endcase
    endfunction

    // flag vector {error, byte done, address hit, stop} placed on its byte positions
    function automatic logic [7:0] to_byte(input logic [3:0] v);
        to_byte = `ISC_RESET_BYTE;
        to_byte[`ISC_IRQ_ERROR_BIT] = v[3];
        to_byte[`ISC_IRQ_BYTE_BIT] = v[2];
        to_byte[`ISC_IRQ_HIT_BIT] = v[1];
        to_byte[`ISC_IRQ_STOP_BIT] = v[0];
    endfunction

    function automatic logic [3:0] from_byte(input logic [7:0] b);
        from_byte = {b[`ISC_IRQ_ERROR_BIT], b[`ISC_IRQ_BYTE_BIT],
                     b[`ISC_IRQ_HIT_BIT], b[`ISC_IRQ_STOP_BIT]};
    endfunction

    // pin synchronisers and edge history
    logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
    logic scl_m_d, scl_s_d, scl_p_d, sda_m_d, sda_s_d, sda_p_d;
    logic scl_rise, scl_fall, bus_start, bus_stop;

    always_comb begin
        scl_m_d = scl_in;
        scl_s_d = scl_m_q;
        scl_p_d = scl_s_q;
        sda_m_d = sda_in;
        sda_s_d = sda_m_q;
        sda_p_d = sda_s_q;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
            {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
        end else if (ce) begin
            {scl_m_q, scl_s_q, scl_p_q} <= {scl_m_d, scl_s_d, scl_p_d};
            {sda_m_q, sda_s_q, sda_p_q} <= {sda_m_d, sda_s_d, sda_p_d};
        end
    end

    // framing events seen on the synchronised lines
    assign scl_rise = scl_s_q & ~scl_p_q;
    assign scl_fall = ~scl_s_q & scl_p_q;
    assign bus_start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
    assign bus_stop = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

    // controller state
    isc_pkg::isc_state_t state_q, state_d, ret_q, ret_d;
    isc_pkg::isc_ctrl_t ctrl_q, ctrl_d;
    logic [3:0] bitcnt_q, bitcnt_d, en_q, en_d, flag_q, flag_d, set_v, clr_v;
    logic [7:0] shift_q, shift_d, rx_data_q, rx_data_d, tx_data_q, tx_data_d;
    logic dir_q, dir_d, sr_q, sr_d, rxnack_q, rxnack_d, busy_q, busy_d;
    logic addressed_q, addressed_d, sda_oe_q, sda_oe_d, scl_oe_q, scl_oe_d;
    logic irq_q, irq_d;
    logic [31:0] rdata_q, rdata_d;

    // register decode
    logic wr_ctrl, wr_enset, wr_enclr, wr_flag, wr_data, rd_data;
    logic [1:0] cmd;
    logic cmd_valid, go_next, go_done, rd_ack, hit_w1, hit, ack_now;
    logic [6:0] rx_addr;

    always_comb begin
        wr_ctrl = reg_req.wr && (reg_req.addr == `ISC_OFF_CTRL);
        wr_enset = reg_req.wr && (reg_req.addr == `ISC_OFF_ENSET);
        wr_enclr = reg_req.wr && (reg_req.addr == `ISC_OFF_ENCLR);
        wr_flag = reg_req.wr && (reg_req.addr == `ISC_OFF_FLAG);
        wr_data = reg_req.wr && (reg_req.addr == `ISC_OFF_DATA);
        rd_data = reg_req.rd && (reg_req.addr == `ISC_OFF_DATA);
        cmd = reg_req.wdata[`ISC_CMD_HI:`ISC_CMD_LO];
        // the reserved code is ignored entirely, it neither acts nor clears flags
        cmd_valid = wr_ctrl && ((cmd == `ISC_CMD_DONE) || (cmd == `ISC_CMD_NEXT));
        hit_w1 = wr_flag && reg_req.wdata[`ISC_IRQ_HIT_BIT];
        rd_ack = rd_data && ctrl_q.smart_ack_on_read;
        // a choice written together with the command is the one that goes out
        ack_now = wr_ctrl ? reg_req.wdata[`ISC_ACK_CHOICE_BIT] : ctrl_q.ack_choice;
        go_next = (cmd_valid && (cmd == `ISC_CMD_NEXT))
            || ((state_q == isc_pkg::ST_ADDR_WAIT) && hit_w1)
            || ((state_q == isc_pkg::ST_RX_WAIT) && rd_ack);
        go_done = cmd_valid && (cmd == `ISC_CMD_DONE);
        rx_addr = shift_q[7:1];
        hit = addr_hit(rx_addr, addr_cfg, ctrl_q.address_match_mode);
    end

    // next-state and register logic; hardware sets win over any clear in the same cycle
    always_comb begin
        state_d = state_q;
        ret_d = ret_q;
        ctrl_d = ctrl_q;
        bitcnt_d = bitcnt_q;
        shift_d = shift_q;
        rx_data_d = rx_data_q;
        tx_data_d = tx_data_q;
        dir_d = dir_q;
        sr_d = sr_q;
        rxnack_d = rxnack_q;
        busy_d = busy_q;
        addressed_d = addressed_q;
        sda_oe_d = sda_oe_q;
        scl_oe_d = scl_oe_q;
        set_v = `ISC_RESET_FLAGS;
        rdata_d = rdata_q;

        // settings land directly, no write synchronisation
        if (wr_ctrl) begin
            ctrl_d.ack_choice = reg_req.wdata[`ISC_ACK_CHOICE_BIT];
            ctrl_d.address_match_mode = reg_req.wdata[`ISC_MATCH_MODE_HI:`ISC_MATCH_MODE_LO];
            ctrl_d.auto_address_ack_enable = reg_req.wdata[`ISC_AUTO_ACK_BIT];
            ctrl_d.group_command_enable = reg_req.wdata[`ISC_GROUP_BIT];
            ctrl_d.smart_ack_on_read = reg_req.wdata[`ISC_RD_ACK_BIT];
        end
        if (wr_data) begin
            tx_data_d = reg_req.wdata[7:0];
        end

        case (state_q)
            isc_pkg::ST_ADDR: begin
                if (scl_rise) begin
                    shift_d = {shift_q[6:0], sda_s_q};
                    bitcnt_d = bitcnt_q + 4'h1;
                end else if (scl_fall && (bitcnt_q == `ISC_BITS_PER_BYTE)) begin
                    bitcnt_d = 4'h0;
                    if (hit) begin
                        dir_d = shift_q[0];
                        addressed_d = 1'h1;
                        if (ctrl_q.auto_address_ack_enable) begin
                            sda_oe_d = ~ctrl_q.ack_choice;
                            state_d = isc_pkg::ST_ACK;
                            ret_d = ctrl_q.ack_choice ? isc_pkg::ST_IDLE :
                                    (shift_q[0] ? isc_pkg::ST_TX_WAIT : isc_pkg::ST_RX);
                        end else begin
                            set_v[1] = 1'h1;
                            scl_oe_d = 1'h1;
                            state_d = isc_pkg::ST_ADDR_WAIT;
                        end
                    end else begin
                        state_d = isc_pkg::ST_IDLE; // another slave's transfer
                    end
                end
            end
            isc_pkg::ST_ADDR_WAIT: begin
                if (go_next) begin
                    sda_oe_d = ~ack_now;
                    scl_oe_d = 1'h0;
                    state_d = isc_pkg::ST_ACK;
                    ret_d = ack_now ? isc_pkg::ST_IDLE :
                            (dir_q ? isc_pkg::ST_TX_WAIT : isc_pkg::ST_RX);
                end else if (go_done) begin
                    scl_oe_d = 1'h0;
                    state_d = isc_pkg::ST_IDLE;
                end
            end
            isc_pkg::ST_ACK: begin
                if (scl_fall) begin
                    sda_oe_d = 1'h0;
                    bitcnt_d = 4'h0;
                    state_d = ret_q;
                    if (ret_q == isc_pkg::ST_TX_WAIT) begin
                        set_v[2] = 1'h1;
                        scl_oe_d = 1'h1;
                    end
                end
            end
            isc_pkg::ST_RX: begin
                if (scl_rise) begin
                    shift_d = {shift_q[6:0], sda_s_q};
                    bitcnt_d = bitcnt_q + 4'h1;
                end else if (scl_fall && (bitcnt_q == `ISC_BITS_PER_BYTE)) begin
                    rx_data_d = shift_q;
                    set_v[2] = 1'h1;
                    scl_oe_d = 1'h1;
                    state_d = isc_pkg::ST_RX_WAIT;
                end
            end
            isc_pkg::ST_RX_WAIT: begin
                if (go_next || go_done) begin
                    sda_oe_d = ~ack_now;
                    scl_oe_d = 1'h0;
                    state_d = isc_pkg::ST_ACK;
                    ret_d = (go_done || ack_now) ? isc_pkg::ST_IDLE :
                            isc_pkg::ST_RX;
                end
            end
            isc_pkg::ST_TX_WAIT: begin
                if (go_next) begin
                    shift_d = tx_data_q;
                    sda_oe_d = ~tx_data_q[7];
                    scl_oe_d = 1'h0;
                    bitcnt_d = `ISC_FIRST_TX_BIT;
                    state_d = isc_pkg::ST_TX;
                end else if (go_done) begin
                    scl_oe_d = 1'h0;
                    state_d = isc_pkg::ST_IDLE;
                end
            end
            isc_pkg::ST_TX: begin
                if (scl_fall) begin
                    if (bitcnt_q == `ISC_BITS_PER_BYTE) begin
                        sda_oe_d = 1'h0;
                        state_d = isc_pkg::ST_TX_ACK;
                    end else begin
                        sda_oe_d = ~shift_q[6];
                        shift_d = {shift_q[6:0], 1'h0};
                        bitcnt_d = bitcnt_q + 4'h1;
                    end
                end
            end
            isc_pkg::ST_TX_ACK: begin
                if (scl_rise) begin
                    rxnack_d = sda_s_q;
                end else if (scl_fall) begin
                    set_v[2] = 1'h1;
                    scl_oe_d = 1'h1;
                    state_d = isc_pkg::ST_TX_WAIT;
                end
            end
            isc_pkg::ST_IDLE: begin
                sda_oe_d = 1'h0;
            end
            default: begin
                state_d = isc_pkg::ST_IDLE;
            end
        endcase

        // start and stop override any byte phase and free both lines
        if (bus_start) begin
            state_d = isc_pkg::ST_ADDR;
            bitcnt_d = 4'h0;
            sda_oe_d = 1'h0;
            scl_oe_d = 1'h0;
            sr_d = busy_q;
            busy_d = 1'h1;
        end else if (bus_stop) begin
            if (ctrl_q.group_command_enable ? addressed_q :
                ((state_q != isc_pkg::ST_IDLE) && (state_q != isc_pkg::ST_ADDR))) begin
                set_v[0] = 1'h1;
            end
            state_d = isc_pkg::ST_IDLE;
            sda_oe_d = 1'h0;
            scl_oe_d = 1'h0;
            busy_d = 1'h0;
            addressed_d = 1'h0;
        end
        set_v[3] = |err_events;

        // read mux, unmapped and reserved bits read as zero
        if (reg_req.rd) begin
            case (reg_req.addr)
                `ISC_OFF_CTRL: begin
                    rdata_d = `ISC_RESET_WORD;
                    rdata_d[`ISC_ACK_CHOICE_BIT] = ctrl_q.ack_choice;
                    rdata_d[`ISC_MATCH_MODE_HI:`ISC_MATCH_MODE_LO] = ctrl_q.address_match_mode;
                    rdata_d[`ISC_AUTO_ACK_BIT] = ctrl_q.auto_address_ack_enable;
                    rdata_d[`ISC_GROUP_BIT] = ctrl_q.group_command_enable;
                    rdata_d[`ISC_RD_ACK_BIT] = ctrl_q.smart_ack_on_read;
                end
                `ISC_OFF_ENCLR, `ISC_OFF_ENSET: rdata_d = {24'h000000, to_byte(en_q)};
                `ISC_OFF_FLAG: rdata_d = {24'h000000, to_byte(flag_q)};
                `ISC_OFF_STATUS: begin
                    rdata_d = `ISC_RESET_WORD;
                    rdata_d[`ISC_ST_CLKHOLD_BIT] = scl_oe_q;
                    rdata_d[`ISC_ST_SR_BIT] = sr_q;
                    rdata_d[`ISC_ST_DIR_BIT] = dir_q;
                    rdata_d[`ISC_ST_RXNACK_BIT] = rxnack_q;
                end
                `ISC_OFF_DATA: rdata_d = {24'h000000, rx_data_q};
                default: rdata_d = `ISC_RESET_WORD;
            endcase
        end
    end

    // flags, enables and interrupt line
    always_comb begin
        clr_v = wr_flag ? from_byte(reg_req.wdata[7:0]) : `ISC_RESET_FLAGS;
        clr_v[2] = clr_v[2] | cmd_valid | wr_data | rd_ack;
        clr_v[1] = clr_v[1] | cmd_valid;
        clr_v[0] = clr_v[0] | cmd_valid;
        flag_d = (flag_q & ~clr_v) | set_v;
        en_d = en_q;
        if (wr_enset) begin
            en_d = en_d | from_byte(reg_req.wdata[7:0]);
        end
        if (wr_enclr) begin
            en_d = en_d & ~from_byte(reg_req.wdata[7:0]);
        end
        irq_d = |(flag_d & en_d);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= isc_pkg::ST_IDLE;
            ret_q <= isc_pkg::ST_IDLE;
            ctrl_q <= '0;
            {bitcnt_q, en_q, flag_q} <= 12'h000;
            {shift_q, rx_data_q, tx_data_q} <= 24'h000000;
            {dir_q, sr_q, rxnack_q, busy_q, addressed_q} <= 5'h00;
            {sda_oe_q, scl_oe_q, irq_q} <= 3'h0;
            rdata_q <= `ISC_RESET_WORD;
        end else if (ce) begin
            state_q <= state_d;
            ret_q <= ret_d;
            ctrl_q <= ctrl_d;
            {bitcnt_q, en_q, flag_q} <= {bitcnt_d, en_d, flag_d};
            {shift_q, rx_data_q, tx_data_q} <= {shift_d, rx_data_d, tx_data_d};
            {dir_q, sr_q, rxnack_q, busy_q, addressed_q} <=
                {dir_d, sr_d, rxnack_d, busy_d, addressed_d};
            {sda_oe_q, scl_oe_q, irq_q} <= {sda_oe_d, scl_oe_d, irq_d};
            rdata_q <= rdata_d;
        end
    end

    // drive levels are constant low flops; only the enables move
    logic drive_lo_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            drive_lo_q <= 1'h0;
        end else if (ce) begin
            drive_lo_q <= 1'h0;
        end
    end

    assign scl_out = drive_lo_q;
    assign sda_out = drive_lo_q;
    assign scl_oe = scl_oe_q;
    assign sda_oe = sda_oe_q;
    assign irq = irq_q;
    assign reg_rdata = rdata_q;

    // checks on the controller
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic quiet;
    assign quiet = ce && !bus_start && !bus_stop;

    sequence s_tx_load;
        quiet && (state_q == isc_pkg::ST_TX_WAIT) && go_next;
    endsequence
    sequence s_tx_first_bit;
        (state_q == isc_pkg::ST_TX) && (sda_oe_q == ~tx_data_q[7]) && !scl_oe_q;
    endsequence

    a_cmd_reads_zero: assert property (ce && reg_req.rd && (reg_req.addr == `ISC_OFF_CTRL)
        |=> reg_rdata[`ISC_CMD_HI:`ISC_CMD_LO] == 2'h0) else $error("command bits read nonzero");
    a_cmd_clears_flags: assert property (ce && cmd_valid && (set_v[2:0] == 3'h0)
        |=> flag_q[2:0] == 3'h0) else $error("command left a flag set");
    a_done_write_ack: assert property (quiet && (state_q == isc_pkg::ST_RX_WAIT) && go_done
        && !ack_now |=> sda_oe_q && (state_q == isc_pkg::ST_ACK)
        && (ret_q == isc_pkg::ST_IDLE)) else $error("done after write byte not acked");
    a_done_read_free: assert property (quiet && (state_q == isc_pkg::ST_TX_WAIT) && go_done
        |=> !sda_oe_q && !scl_oe_q && (state_q == isc_pkg::ST_IDLE))
        else $error("done after read byte did not release");
    a_next_write_rx: assert property (quiet && (state_q == isc_pkg::ST_ADDR_WAIT) && go_next
        && !dir_q && !ack_now |=> (state_q == isc_pkg::ST_ACK)
        && (ret_q == isc_pkg::ST_RX) && sda_oe_q) else $error("next in write not acked");
    a_read_ack_byte_done_flag: assert property (quiet && (state_q == isc_pkg::ST_ACK) && scl_fall
        && (ret_q == isc_pkg::ST_TX_WAIT) |=> flag_q[2] && scl_oe_q && !sda_oe_q)
        else $error("no data ready after read address");
    a_tx_first_bit: assert property (s_tx_load |=> s_tx_first_bit)
        else $error("transmit byte not started");
    a_addr_hit_flag: assert property (quiet && (state_q == isc_pkg::ST_ADDR) && scl_fall
        && (bitcnt_q == `ISC_BITS_PER_BYTE) && hit && !ctrl_q.auto_address_ack_enable
        |=> flag_q[1] && scl_oe_q ##1 !ce || flag_q[1] || !scl_oe_q)
        else $error("matching address not flagged");
    a_auto_ack: assert property (quiet && (state_q == isc_pkg::ST_ADDR) && scl_fall
        && (bitcnt_q == `ISC_BITS_PER_BYTE) && hit && ctrl_q.auto_address_ack_enable
        && !ctrl_q.ack_choice |=> (state_q == isc_pkg::ST_ACK) && sda_oe_q && !scl_oe_q)
        else $error("auto ack did not answer");
    a_group_stop: assert property (ce && bus_stop && ctrl_q.group_command_enable
        && !addressed_q && !flag_q[0] |=> !flag_q[0])
        else $error("stop flagged without being addressed");
    a_enable_clear: assert property (ce && wr_enclr && reg_req.wdata[`ISC_IRQ_STOP_BIT]
        |=> !en_q[0]) else $error("enable clear ignored");
    a_enable_set: assert property (ce && wr_enset && !wr_enclr
        && reg_req.wdata[`ISC_IRQ_ERROR_BIT] |=> en_q[3]) else $error("enable set ignored");
    a_error_sets: assert property (ce && (|err_events) |=> flag_q[3])
        else $error("error source not flagged");
    a_error_clear: assert property (ce && wr_flag && reg_req.wdata[`ISC_IRQ_ERROR_BIT]
        && !(|err_events) |=> !flag_q[3]) else $error("error flag not cleared");
    a_irq_follows: assert property (ce |=> irq_q == |(flag_q & en_q))
        else $error("interrupt line disagrees with flags");
endmodule // isc_slave_ctrl

// ==== tb/isc_master_model.sv ====
// behavioural two-wire bus master with open-drain drive
`timescale 1ns/1ps
module isc_master_model (
    input wire logic scl, // resolved clock line
    input wire logic sda, // resolved data line
    output logic scl_rel, // high lets the clock float up
    output logic sda_rel // high lets the data float up
);
    // idle bus: both lines released to their pull-ups
    initial begin
        scl_rel = 1'b1;
        sda_rel = 1'b1;
    end
    // data moves only while the clock is low; a stretch delays the high phase
    task automatic bit_io(input logic b, output logic s);
        sda_rel = b;
        #80 scl_rel = 1'b1;
        wait (scl === 1'b1);
        #40 s = sda;
        #40 scl_rel = 1'b0;
    endtask
    // start condition: data falls while the clock is high
    task automatic start();
        sda_rel = 1'b1;
        scl_rel = 1'b1;
        #80 sda_rel = 1'b0;
        #80 scl_rel = 1'b0;
    endtask
    // eight bits msb first, then the receiver's answer bit
    task automatic xfer(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, ack);
    endtask
    // eight bits read msb first with data released, then our answer bit
    task automatic rcv(input logic a, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(a, s);
    endtask
    // stop condition: data rises while the clock is high
    task automatic stop();
        sda_rel = 1'b0;
        #80 scl_rel = 1'b1;
        wait (scl === 1'b1);
        #80 sda_rel = 1'b1;
        #80;
    endtask
endmodule // isc_master_model

// ==== tb/tb.sv ====
// self-checking bench of the two-wire slave controller
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin mismatches++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module tb;
    logic clk, rst, irq, scl_oe, sda_oe, scl_w, sda_w, scl_rel, sda_rel, ack;
    logic [31:0] rdata, v;
    logic [3:0] err;
    isc_pkg::isc_reg_req_t req;
    isc_pkg::isc_addr_cfg_t cfg;
    int mismatches, check_count;
    logic [1:0] md [6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
    logic [6:0] pri [6] = '{7'h50, 7'h50, 7'h50, 7'h50, 7'h40, 7'h40};
    logic [6:0] sec [6] = '{7'h0F, 7'h0F, 7'h23, 7'h23, 7'h30, 7'h30};
    logic [6:0] adr [6] = '{7'h5A, 7'h60, 7'h23, 7'h51, 7'h40, 7'h2F};
    logic hit [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    // open-drain wires: low when either party pulls
    assign scl_w = scl_rel & ~scl_oe;
    assign sda_w = sda_rel & ~sda_oe;
    isc_slave_ctrl isc_slave_ctrl_i (.clk(clk), .rst(rst), .ce(1'b1), .reg_req(req),
        .reg_rdata(rdata), .addr_cfg(cfg), .err_events(err), .scl_in(scl_w), .sda_in(sda_w),
        .scl_out(), .scl_oe(scl_oe), .sda_out(), .sda_oe(sda_oe), .irq(irq));
    isc_master_model isc_master_model_i (.scl(scl_w), .sda(sda_w), .scl_rel(scl_rel),
        .sda_rel(sda_rel));
    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // register accesses, one strobe cycle each
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) #1 req = '{1'b1, 1'b0, a, d};
        @(posedge clk) #1 req.wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk) #1 req = '{1'b0, 1'b1, a, 32'h0000_0000};
        @(posedge clk) #1 req.rd = 1'b0;
        @(posedge clk) #1 d = rdata;
    endtask
    // bounded wait for the interrupt line
    task automatic wait_irq();
        for (int i = 0; i < 4000 && irq !== 1'b1; i++) @(posedge clk);
    endtask
    task automatic t_regs();
        rd(8'h14, v); `CHK(v, 32'h0000_0000)
        wr(8'h16, 32'h0000_00FF);
        rd(8'h14, v); `CHK(v, 32'h0000_0087)
        rd(8'h16, v); `CHK(v, 32'h0000_0087)
        wr(8'h14, 32'h0000_0005);
        rd(8'h16, v); `CHK(v, 32'h0000_0082)
        wr(8'h04, 32'hFFFF_FFFF);
        rd(8'h04, v); `CHK(v, 32'h0004_C700)
        rd(8'h30, v); `CHK(v, 32'h0000_0000)
    endtask
    // each error source alone, then clear by writing one
    task automatic t_err();
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) #1 err = 4'h1 << i;
            @(posedge clk) #1 err = 4'h0;
            rd(8'h18, v); `CHK(v, 32'h0000_0080)
            `CHK(irq, 1'b1)
            wr(8'h18, 32'h0000_0080);
            rd(8'h18, v); `CHK(v, 32'h0000_0000)
        end
    endtask
    // every address mode, a hit and a miss each, answered by auto ack
    task automatic t_modes();
        for (int i = 0; i < 6; i++) begin
            cfg = '{pri[i], sec[i]};
            wr(8'h04, {16'h0000, md[i], 14'h0400});
            isc_master_model_i.start();
            isc_master_model_i.xfer({adr[i], 1'b0}, ack);
            `CHK(ack, ~hit[i])
            isc_master_model_i.stop();
            rd(8'h18, v); `CHK(v[0], hit[i])
            wr(8'h18, 32'h0000_0001);
        end
    endtask
    // software-driven write: ack the address, nack the data byte
    task automatic t_cmd();
        wr(8'h04, 32'h0000_0000);
        wr(8'h16, 32'h0000_0004);
        cfg = '{7'h50, 7'h00};
        isc_master_model_i.start();
        fork
            isc_master_model_i.xfer(8'hA0, ack);
            begin
                wait_irq();
                rd(8'h18, v); `CHK(v, 32'h0000_0002)
                wr(8'h04, 32'h0003_0000);
            end
        join
        `CHK(ack, 1'b0)
        rd(8'h18, v); `CHK(v, 32'h0000_0000)
        fork
            isc_master_model_i.xfer(8'h3C, ack);
            begin
                wait_irq();
                rd(8'h28, v); `CHK(v[7:0], 8'h3C)
                wr(8'h04, 32'h0006_0000);
            end
        join
        `CHK(ack, 1'b1)
        isc_master_model_i.stop();
    endtask
    // auto-acked read: one byte out, master nacks, done command releases
    task automatic t_read();
        logic [7:0] d;
        wr(8'h04, 32'h0000_0400);
        isc_master_model_i.start();
        fork
            isc_master_model_i.xfer(8'hA1, ack);
            begin
                wait_irq();
                wr(8'h28, 32'h0000_00A5);
                wr(8'h04, 32'h0003_0400);
            end
        join
        `CHK(ack, 1'b0)
        isc_master_model_i.rcv(1'b1, d);
        `CHK(d, 8'hA5)
        wait_irq();
        rd(8'h1A, v); `CHK(v, 32'h0000_008C)
        wr(8'h04, 32'h0002_0400);
        `CHK(scl_oe, 1'b0)
        isc_master_model_i.stop();
    endtask
    task automatic results();
        $display("mismatches %0d check_count %0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // reset for four cycles, idle bus, then the scenarios
    initial begin
        rst = 1'b1;
        req = '0;
        cfg = '0;
        err = 4'h0;
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        t_regs();
        t_err();
        t_modes();
        t_cmd();
        t_read();
        results();
    end
    // a stuck handshake cannot hang the run
    initial begin
        #400000 mismatches++;
        results();
    end
endmodule // tb
